// ---- pkg/aux_alu_regs.vh ----
// Register map, field positions and code tables of the aux ALU decoder
`ifndef AUX_ALU_REGS_VH
`define AUX_ALU_REGS_VH

// Register byte offsets
`define AUX_OFS_CTRL      4'h0
`define AUX_OFS_STATUS    4'h4
`define AUX_OFS_COUNT     4'h8
`define AUX_OFS_LAST_IR   4'hC

// Control fields and reset value
`define AUX_CTRL_EN_BIT     0
`define AUX_CTRL_FORCE_BIT  1
`define AUX_CTRL_FCODE_LSB  4
`define AUX_CTRL_RESET      8'h01

// Status fields
`define AUX_ST_FUNC_LSB     0
`define AUX_ST_DRIVE_BIT    4
`define AUX_ST_SERIAL_BIT   5
`define AUX_ST_ROTC_BIT     6
`define AUX_ST_SHR_BIT      7
`define AUX_ST_SHL_BIT      8
`define AUX_ST_CLASS_LSB    9
`define AUX_ST_UNKNOWN_BIT  12

// ALU function codes
`define AUX_FN_ZERO     4'h0
`define AUX_FN_NOT_A    4'h1
`define AUX_FN_A_INC    4'h2
`define AUX_FN_A_DEC    4'h3
`define AUX_FN_A_SUB_B  4'h4
`define AUX_FN_PASS_A   4'h5
`define AUX_FN_PASS_B   4'h6
`define AUX_FN_A_ADD_B  4'h8
`define AUX_FN_A_AND_B  4'h9
`define AUX_FN_A_CLR_B  4'hA
`define AUX_FN_A_OR_B   4'hB
`define AUX_FN_A_XOR_B  4'hC

// Two-operand group, instruction bits 14:12
`define AUX_OP_MOVE     3'h1
`define AUX_OP_CMP      3'h2
`define AUX_OP_BTST     3'h3
`define AUX_OP_BCLR     3'h4
`define AUX_OP_BSET     3'h5
`define AUX_OP_ADDSUB   3'h6
// Exclusive-or, instruction bits 15:9
`define AUX_OP_XOR      7'h3C
// One-operand group, instruction bits 14:6
`define AUX_OP_CLR      9'h028
`define AUX_OP_COM      9'h029
`define AUX_OP_INC      9'h02A
`define AUX_OP_DEC      9'h02B
`define AUX_OP_NEG      9'h02C
`define AUX_OP_ADC      9'h02D
`define AUX_OP_SUBC     9'h02E
`define AUX_OP_TST      9'h02F
`define AUX_OP_ROR      9'h030
`define AUX_OP_ROL      9'h031
`define AUX_OP_ASR      9'h032
`define AUX_OP_ASL      9'h033
// Full-width one-operand codes, instruction bits 15:6
`define AUX_OP_BSWAP    10'h003
`define AUX_OP_MARK     10'h034
`define AUX_OP_MFPI     10'h035
`define AUX_OP_MTPI     10'h036
`define AUX_OP_SEXT     10'h037
`define AUX_OP_MTPS     10'h234
`define AUX_OP_MFPD     10'h235
`define AUX_OP_MTPD     10'h236
`define AUX_OP_MFPS     10'h237

`endif

// ---- rtl/aux_alu_decoder.v ----
// Auxiliary ALU function decoder with Avalon-MM control registers
//
// Summary of operation
// RULE1: Choose the ALU operation for scratchpad-op-B combine steps.
// RULE2: Two-operand table drives the function code only during setup strobe.
// RULE3: One-operand table drives the function code only during setup strobe.
// RULE4: Move gives 0101 pass A; compare and subtract give 0100.
// RULE5: Add gives 1000, A plus B.
// RULE6: Bit test 1001, bit clear 1010, bit set 1011.
// RULE7: Exclusive-or gives 1100.
// RULE8: Clear gives 0000, a zero result.
// RULE9: Complement gives 0001, inverse of A.
// RULE10: Increment gives 0010.
// RULE11: Decrement gives 0011.
// RULE12: Negate gives 0100.
// RULE13: Add-carry gives 0101 with carry clear, 0010 with carry set.
// RULE14: Subtract-carry gives 0101 with carry clear, 0011 with carry set.
// RULE15: Byte swap, test, previous-space and status moves give 0101.
// RULE16: Rotates and arithmetic shifts give 0110, pass B.
// RULE17: Sign extend gives 0000 or 0110 by negative flag; mark gives 0000.
// RULE18: Rotate/shift table yields the B register shift controls.
// RULE19: Shift-in and rotate carry come from shift kind, B lsb, N, C.
// RULE20: Shift-in select feeds the byte multiplexer for bit 7.
// RULE21: Rotate carry feeds the carry and overflow logic.
// RULE22: Microcode strobes setup on the B-to-B step before each combine.
// RULE23: Outputs follow instruction and flags in the strobe cycle.
`timescale 1ns/10ps
`include "aux_alu_regs.vh"

module aux_alu_decoder #(
    parameter CNT_W = 32                  // Setup strobe counter width
) (
    input  wire        clk_sys,           // System clock, 200 MHz
    input  wire        rst,               // Async reset, active high
    input  wire [15:0] instr,             // Current instruction register
    input  wire        aux_setup,         // Setup strobe from microcode
    input  wire        negative_flag,     // Condition code N
    input  wire        carry_flag,        // Condition code C
    input  wire        breg_lsb,          // B register bit 0
    output reg  [3:0]  alu_func_q,        // ALU function code
    output reg         func_drive_q,      // Function code is valid
    output reg         shift_right_q,     // Shift B right
    output reg         shift_left_q,      // Shift B left
    output reg         serial_shift_q,    // Shift-in bit to byte_shift_multiplexer
    output reg         rotate_carry_q,    // New carry to C/V logic
    input  wire [3:0]  avs_address,       // Byte address
    input  wire        avs_read,          // Read request
    input  wire        avs_write,         // Write request
    input  wire [31:0] avs_writedata,     // Write data
    input  wire [3:0]  avs_byteenable,    // Byte lanes
    output reg  [31:0] avs_readdata_q,    // Read data
    output reg         avs_waitrequest_q  // Wait request
);

    localparam [2:0] CL_NONE  = 3'h0;
    localparam [2:0] CL_TWO   = 3'h1;
    localparam [2:0] CL_ONE   = 3'h2;
    localparam [2:0] CL_SHIFT = 3'h3;

    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    // Control and status state
    reg  [7:0]       ctrl_q;
    reg  [CNT_W-1:0] setup_cnt_q;
    reg  [15:0]      last_ir_q;
    reg  [2:0]       class_q;
    reg              unknown_q;

    // Decode results
    reg  [3:0]       func_d;
    reg  [2:0]       class_d;
    reg              known_d;
    reg              shr_d;
    reg              shl_d;
    reg              serial_d;
    reg              rotc_d;

    wire [2:0]  two_op  = instr[14:12];
    wire [8:0]  one_op  = instr[14:6];
    wire [9:0]  full_op = instr[15:6];
    wire        dec_en  = ctrl_q[`AUX_CTRL_EN_BIT];
    wire        force_en = ctrl_q[`AUX_CTRL_FORCE_BIT];
    wire [3:0]  force_fn = ctrl_q[`AUX_CTRL_FCODE_LSB +: 4];

    // Bus request in its wait cycle, and write being answered this cycle
    wire bus_req  = (avs_read | avs_write) & avs_waitrequest_q;
    wire wr_ack   = avs_write & ~avs_waitrequest_q;
    wire clr_unk  = wr_ack & (avs_address == `AUX_OFS_STATUS) &
                    avs_byteenable[1] &
                    avs_writedata[`AUX_ST_UNKNOWN_BIT];
    wire clr_cnt  = wr_ack & (avs_address == `AUX_OFS_COUNT) &
                    (|avs_byteenable);

    // Function tables
    always @* begin
        func_d  = `AUX_FN_ZERO;
        class_d = CL_NONE;
        known_d = 1'b1;
        if (two_op != 3'h0 && two_op != 3'h7) begin
            class_d = CL_TWO;
            case (two_op)
                `AUX_OP_MOVE: begin
                    func_d = `AUX_FN_PASS_A; // RULE4
                end
                `AUX_OP_CMP: begin
                    func_d = `AUX_FN_A_SUB_B; // RULE4
                end
                `AUX_OP_BTST: begin
                    func_d = `AUX_FN_A_AND_B; // RULE6
                end
                `AUX_OP_BCLR: begin
                    func_d = `AUX_FN_A_CLR_B; // RULE6
                end
                `AUX_OP_BSET: begin
                    func_d = `AUX_FN_A_OR_B; // RULE6
                end
                `AUX_OP_ADDSUB: begin
                    // Bit 15 tells subtract from add
                    if (instr[15]) begin
                        func_d = `AUX_FN_A_SUB_B; // RULE4
                    end else begin
                        func_d = `AUX_FN_A_ADD_B; // RULE5
                    end
                end
                default: begin
                    known_d = 1'b0;
                end
            endcase
        end else if (instr[15:9] == `AUX_OP_XOR) begin
            class_d = CL_TWO;
            func_d  = `AUX_FN_A_XOR_B; // RULE7
        end else begin
            class_d = CL_ONE;
            case (one_op)
                `AUX_OP_CLR: begin
                    func_d = `AUX_FN_ZERO; // RULE8
                end
                `AUX_OP_COM: begin
                    func_d = `AUX_FN_NOT_A; // RULE9
                end
                `AUX_OP_INC: begin
                    func_d = `AUX_FN_A_INC; // RULE10
                end
                `AUX_OP_DEC: begin
                    func_d = `AUX_FN_A_DEC; // RULE11
                end
                `AUX_OP_NEG: begin
                    func_d = `AUX_FN_A_SUB_B; // RULE12
                end
                `AUX_OP_ADC: begin
                    if (carry_flag) begin
                        func_d = `AUX_FN_A_INC; // RULE13
                    end else begin
                        func_d = `AUX_FN_PASS_A; // RULE13
                    end
                end
                `AUX_OP_SUBC: begin
                    if (carry_flag) begin
                        func_d = `AUX_FN_A_DEC; // RULE14
                    end else begin
                        func_d = `AUX_FN_PASS_A; // RULE14
                    end
                end
                `AUX_OP_TST: begin
                    func_d = `AUX_FN_PASS_A; // RULE15
                end
                `AUX_OP_ROR, `AUX_OP_ROL,
                `AUX_OP_ASR, `AUX_OP_ASL: begin
                    class_d = CL_SHIFT;
                    func_d  = `AUX_FN_PASS_B; // RULE16
                end
                default: begin
                    case (full_op)
                        `AUX_OP_BSWAP, `AUX_OP_MFPI,
                        `AUX_OP_MTPI, `AUX_OP_MTPS,
                        `AUX_OP_MFPD, `AUX_OP_MTPD,
                        `AUX_OP_MFPS: begin
                            func_d = `AUX_FN_PASS_A; // RULE15
                        end
                        `AUX_OP_MARK: begin
                            func_d = `AUX_FN_ZERO; // RULE17
                        end
                        `AUX_OP_SEXT: begin
                            if (negative_flag) begin
                                func_d = `AUX_FN_PASS_B; // RULE17
                            end else begin
                                func_d = `AUX_FN_ZERO; // RULE17
                            end
                        end
                        default: begin
                            class_d = CL_NONE;
                            known_d = 1'b0;
                        end
                    endcase
                end
            endcase
        end
    end

    // Rotate/shift table; word view, N stands for the old bit 15
    always @* begin
        shr_d    = 1'b0;
        shl_d    = 1'b0;
        serial_d = 1'b0;
        rotc_d   = carry_flag;
        if (class_d == CL_SHIFT) begin
            case (one_op)
                `AUX_OP_ROR: begin
                    shr_d    = 1'b1; // RULE18
                    serial_d = carry_flag; // RULE19
                    rotc_d   = breg_lsb; // RULE19
                end
                `AUX_OP_ROL: begin
                    shl_d    = 1'b1; // RULE18
                    serial_d = carry_flag; // RULE19
                    rotc_d   = negative_flag; // RULE19
                end
                `AUX_OP_ASR: begin
                    shr_d    = 1'b1; // RULE18
                    serial_d = negative_flag; // RULE19
                    rotc_d   = breg_lsb; // RULE19
                end
                `AUX_OP_ASL: begin
                    shl_d    = 1'b1; // RULE18
                    serial_d = 1'b0; // RULE19
                    rotc_d   = negative_flag; // RULE19
                end
                default: begin
                    shr_d = 1'b0;
                end
            endcase
        end
    end

    // Registered outputs, re-evaluated on every setup strobe while decoding is enabled
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            alu_func_q     <= `AUX_FN_ZERO;
            func_drive_q   <= 1'b0;
            shift_right_q  <= 1'b0;
            shift_left_q   <= 1'b0;
            serial_shift_q <= 1'b0;
            rotate_carry_q <= 1'b0;
            class_q        <= CL_NONE;
            last_ir_q      <= 16'h0000;
        end else begin
            // Drive only in the cycle after a strobe with decoding enabled
            func_drive_q <= aux_setup & dec_en; // RULE2 RULE3
            if (aux_setup && dec_en) begin
                // Forced code overrides the function tables for bring-up
                if (force_en) begin
                    alu_func_q <= force_fn;
                end else begin
                    alu_func_q <= func_d; // RULE1 RULE23
                end
                shift_right_q  <= shr_d; // RULE18
                shift_left_q   <= shl_d; // RULE18
                serial_shift_q <= serial_d; // RULE20
                rotate_carry_q <= rotc_d; // RULE21
                class_q        <= class_d;
                last_ir_q      <= instr;
            end else begin
                alu_func_q     <= `AUX_FN_ZERO; // RULE2 RULE3
                shift_right_q  <= 1'b0;
                shift_left_q   <= 1'b0;
                serial_shift_q <= 1'b0;
                rotate_carry_q <= rotate_carry_q;
            end
        end
    end

    // Sticky unknown-instruction flag; a new hit beats the clear
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unknown_q <= 1'b0;
        end else if (aux_setup && dec_en && !known_d) begin
            unknown_q <= 1'b1;
        end else if (clr_unk) begin
            unknown_q <= 1'b0;
        end
    end

    // Strobe counter; a strobe in the clear cycle counts as one
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            setup_cnt_q <= {CNT_W{1'b0}};
        end else if (clr_cnt) begin
            if (aux_setup) begin
                setup_cnt_q <= CNT_ONE;
            end else begin
                setup_cnt_q <= {CNT_W{1'b0}};
            end
        end else if (aux_setup) begin
            setup_cnt_q <= setup_cnt_q + CNT_ONE;
        end
    end

    // Control register write
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q <= `AUX_CTRL_RESET;
        end else if (wr_ack && avs_address == `AUX_OFS_CTRL &&
                     avs_byteenable[0]) begin
            ctrl_q <= avs_writedata[7:0];
        end
    end

    // Read mux
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h00000000;
        case (avs_address)
            `AUX_OFS_CTRL: begin
                rd_d[7:0] = ctrl_q;
            end
            `AUX_OFS_STATUS: begin
                rd_d[`AUX_ST_FUNC_LSB +: 4]  = alu_func_q;
                rd_d[`AUX_ST_DRIVE_BIT]      = func_drive_q;
                rd_d[`AUX_ST_SERIAL_BIT]     = serial_shift_q;
                rd_d[`AUX_ST_ROTC_BIT]       = rotate_carry_q;
                rd_d[`AUX_ST_SHR_BIT]        = shift_right_q;
                rd_d[`AUX_ST_SHL_BIT]        = shift_left_q;
                rd_d[`AUX_ST_CLASS_LSB +: 3] = class_q;
                rd_d[`AUX_ST_UNKNOWN_BIT]    = unknown_q;
            end
            `AUX_OFS_COUNT: begin
                rd_d[CNT_W-1:0] = setup_cnt_q;
            end
            `AUX_OFS_LAST_IR: begin
                rd_d[15:0] = last_ir_q;
            end
            default: begin
                rd_d = 32'h00000000;
            end
        endcase
    end

    // One wait cycle per access keeps read data registered
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_waitrequest_q <= 1'b1;
            avs_readdata_q    <= 32'h00000000;
        end else if (bus_req) begin
            avs_waitrequest_q <= 1'b0;
            if (avs_read) begin
                avs_readdata_q <= rd_d;
            end
        end else begin
            avs_waitrequest_q <= 1'b1;
        end
    end

endmodule

// ---- dv/aad_dec_properties.sv ----
// Port assertions for the aux ALU decoder
`timescale 1ns/10ps
module aad_dec_props (
    input wire logic        clk_sys,           // Clock
    input wire logic        rst,               // Reset
    input wire logic [15:0] instr,             // Instruction
    input wire logic        aux_setup,         // Strobe
    input wire logic        negative_flag,     // N
    input wire logic        carry_flag,        // C
    input wire logic        breg_lsb,          // B bit 0
    input wire logic [3:0]  alu_func_q,        // Code
    input wire logic        func_drive_q,      // Valid
    input wire logic        shift_right_q,     // Right
    input wire logic        shift_left_q,      // Left
    input wire logic        serial_shift_q,    // Shift-in
    input wire logic        rotate_carry_q,    // New carry
    input wire logic [3:0]  avs_address,       // Address
    input wire logic        avs_read,          // Read
    input wire logic        avs_write,         // Write
    input wire logic [31:0] avs_writedata,     // Write data
    input wire logic [3:0]  avs_byteenable,    // Lanes
    input wire logic [31:0] avs_readdata_q,    // Read data
    input wire logic        avs_waitrequest_q  // Wait
);
    logic en_q, fr_q;
    wire  tk = aux_setup && en_q;
    // Table codes only; a forced code replaces them
    wire  tt = tk && !fr_q;
    // Decode enable and force as last written over the bus
    always @(posedge clk_sys or posedge rst)
        if (rst)
            {fr_q, en_q} <= 2'b01;
        else if (avs_write && !avs_waitrequest_q && avs_address == 4'h0
                 && avs_byteenable[0])
            {fr_q, en_q} <= avs_writedata[1:0];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_drive_on_strobe: assert property (func_drive_q == $past(tk))
        else $error("drive does not follow strobe");
    a_idle_quiet: assert property (!func_drive_q |-> alu_func_q == 4'h0
        && !shift_right_q && !shift_left_q && !serial_shift_q)
        else $error("outputs active without drive");
    a_add_code: assert property (tt && instr[15:12] == 4'h6
        |=> alu_func_q == 4'h8) else $error("add code wrong");
    a_xor_code: assert property (tt && instr[15:9] == 7'h3C
        |=> alu_func_q == 4'hC) else $error("xor code wrong");
    a_adc_carry: assert property (tt && instr[14:6] == 9'h02D
        |=> alu_func_q == ($past(carry_flag) ? 4'h2 : 4'h5))
        else $error("add-carry code wrong");
    a_sext_neg: assert property (tt && instr[15:6] == 10'h037
        |=> alu_func_q == ($past(negative_flag) ? 4'h6 : 4'h0))
        else $error("sign extend code wrong");
    a_ror_ctrl: assert property (tk && instr[14:6] == 9'h030
        |=> shift_right_q && serial_shift_q == $past(carry_flag)
        && rotate_carry_q == $past(breg_lsb)) else $error("rotate right");
    a_asl_ctrl: assert property (tk && instr[14:6] == 9'h033
        |=> shift_left_q && !serial_shift_q
        && rotate_carry_q == $past(negative_flag)) else $error("shift left");
    a_carry_holds: assert property (!aux_setup |=> $stable(rotate_carry_q))
        else $error("rotate carry changed without strobe");
endmodule

bind aux_alu_decoder aad_dec_props u_props (
    .clk_sys(clk_sys), .rst(rst), .instr(instr), .aux_setup(aux_setup),
    .negative_flag(negative_flag), .carry_flag(carry_flag),
    .breg_lsb(breg_lsb), .alu_func_q(alu_func_q),
    .func_drive_q(func_drive_q), .shift_right_q(shift_right_q),
    .shift_left_q(shift_left_q), .serial_shift_q(serial_shift_q),
    .rotate_carry_q(rotate_carry_q), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata_q(avs_readdata_q), .avs_waitrequest_q(avs_waitrequest_q));

// ---- dv/aad_ucode_model.sv ----
// Microcode-side model: instruction, flags and setup strobe
`timescale 1ns/10ps
module aad_ucode_model (
    input  wire logic        clk_sys,       // Clock
    input  wire logic        rst,           // Reset
    input  wire logic        cmd_valid,     // Step wanted
    input  wire logic [15:0] cmd_instr,     // Instruction
    input  wire logic        cmd_n,         // N
    input  wire logic        cmd_c,         // C
    input  wire logic        cmd_b,         // B bit 0
    output logic      [15:0] instr,         // To decoder
    output logic             aux_setup,     // Setup strobe
    output logic             negative_flag, // N
    output logic             carry_flag,    // C
    output logic             breg_lsb       // B bit 0
);
    // Lines keep moving between steps, so nothing may be read then
    always @(posedge clk_sys or posedge rst)
        if (rst) begin
            aux_setup <= 1'b0;
            {instr, negative_flag, carry_flag, breg_lsb} <= 19'h00000;
        end else begin
            aux_setup <= cmd_valid;
            {instr, negative_flag, carry_flag, breg_lsb} <=
                {cmd_instr, cmd_n, cmd_c, cmd_b};
        end
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the aux ALU decoder
`timescale 1ns/10ps
module testbench;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid = 1'b0;
    logic [15:0] cmd_instr = 16'h0000;
    logic        cmd_n = 1'b0, cmd_c = 1'b0, cmd_b = 1'b0;
    logic [15:0] instr;
    logic        aux_setup, negative_flag, carry_flag, breg_lsb;
    logic [3:0]  alu_func_q;
    logic        func_drive_q, shift_right_q, shift_left_q;
    logic        serial_shift_q, rotate_carry_q, avs_waitrequest_q;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h0;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata_q, rd;
    logic        en_m = 1'b1, exp_v = 1'b0, rc_m = 1'b0, frc_m = 1'b0;
    logic [3:0]  fc_m = 4'h0;
    logic [6:0]  exp_o = 7'h00;
    logic [15:0] last_m = 16'h0000;
    logic [9:0]  full [9] = '{10'h003, 10'h034, 10'h035, 10'h036,
                              10'h037, 10'h234, 10'h235, 10'h236, 10'h237};
    int          n_fail = 0, n_checks = 0, cyc = 0;

    initial forever #2.5 clk_sys = ~clk_sys;

    aux_alu_decoder DUT (.clk_sys(clk_sys), .rst(rst), .instr(instr),
        .aux_setup(aux_setup), .negative_flag(negative_flag),
        .carry_flag(carry_flag), .breg_lsb(breg_lsb),
        .alu_func_q(alu_func_q), .func_drive_q(func_drive_q),
        .shift_right_q(shift_right_q), .shift_left_q(shift_left_q),
        .serial_shift_q(serial_shift_q), .rotate_carry_q(rotate_carry_q),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata_q(avs_readdata_q),
        .avs_waitrequest_q(avs_waitrequest_q));
    aad_ucode_model u_uc (.clk_sys(clk_sys), .rst(rst),
        .cmd_valid(cmd_valid), .cmd_instr(cmd_instr), .cmd_n(cmd_n),
        .cmd_c(cmd_c), .cmd_b(cmd_b), .instr(instr), .aux_setup(aux_setup),
        .negative_flag(negative_flag), .carry_flag(carry_flag),
        .breg_lsb(breg_lsb));

    function automatic logic [7:0] model(input logic [15:0] ir,
                                         input logic n, c, b);
        logic [3:0] f;
        logic [3:0] s;
        f = 4'h0;
        s = {3'b000, c};
        if (ir[15:9] == 7'h3C) f = 4'hC;
        else case (ir[14:12])
            3'h1: f = 4'h5;
            3'h2: f = 4'h4;
            3'h3: f = 4'h9;
            3'h4: f = 4'hA;
            3'h5: f = 4'hB;
            3'h6: f = ir[15] ? 4'h4 : 4'h8;
            3'h0: case (ir[14:6])
                9'h028: f = 4'h0;
                9'h029: f = 4'h1;
                9'h02A: f = 4'h2;
                9'h02B: f = 4'h3;
                9'h02C: f = 4'h4;
                9'h02D: f = c ? 4'h2 : 4'h5;
                9'h02E: f = c ? 4'h3 : 4'h5;
                9'h02F: f = 4'h5;
                9'h030: {f, s} = {4'h6, 2'b10, c, b};
                9'h031: {f, s} = {4'h6, 2'b01, c, n};
                9'h032: {f, s} = {4'h6, 2'b10, n, b};
                9'h033: {f, s} = {4'h6, 2'b01, 1'b0, n};
                default: case (ir[15:6])
                    10'h037: f = n ? 4'h6 : 4'h0;
                    10'h003, 10'h035, 10'h036, 10'h234, 10'h235,
                    10'h236, 10'h237: f = 4'h5;
                    default: f = 4'h0;
                endcase
            endcase
            default: f = 4'h0;
        endcase
        return {f, s};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Holds the request until the edge that ends the wait
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest_q !== 1'b0);
        rd = avs_readdata_q;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (wr && a == 4'h0) {fc_m, frc_m, en_m} <= {d[7:4], d[1:0]};
        // Idle edge so the next call never re-raises in this step
        @(posedge clk_sys);
    endtask

    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF);
        chk($sformatf("reg %h", a), rd, e);
    endtask

    task automatic op(input logic [15:0] ir, input logic [1:0] nc);
        cmd_valid <= 1'b1;
        cmd_instr <= ir;
        {cmd_n, cmd_c, cmd_b} <= {nc, 1'($urandom)};
        @(posedge clk_sys);
    endtask

    task automatic idle(input int n);
        cmd_valid <= 1'b0;
        repeat (n) begin
            {cmd_instr, cmd_n, cmd_c, cmd_b} <= 19'($urandom);
            @(posedge clk_sys);
        end
    endtask

    // Reference samples what the decoder takes at each edge
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        exp_v <= aux_setup && en_m && !rst;
        if (aux_setup && en_m && !rst) begin
            {exp_o, rc_m} <= model(instr, negative_flag, carry_flag,
                                   breg_lsb);
            if (frc_m) exp_o[6:3] <= fc_m;
            last_m <= instr;
        end
        if (cyc == 8000) begin
            n_fail++;
            report_and_stop();
        end
    end

    always @(negedge clk_sys)
        if (!rst) begin
            chk("drive", func_drive_q, exp_v);
            chk("outputs", {alu_func_q, shift_right_q, shift_left_q, serial_shift_q}, exp_v ? exp_o : 7'h00);
            chk("rotate carry", rotate_carry_q, rc_m);
        end

    initial begin
        void'($urandom(32'hCC9C));
        repeat (3) @(posedge clk_sys);
        chk("reset wait", avs_waitrequest_q, 1'b1);
        chk("reset drive", func_drive_q, 1'b0);
        rst <= 1'b0;
        @(posedge clk_sys);
        rdc(4'h0, 32'h1);
        rdc(4'h4, 32'h0);
        rdc(4'h8, 32'h0);
        rdc(4'hC, 32'h0);
        bus(1'b1, 4'h2, 32'hFFFFFFFE, 4'hF);
        rdc(4'h2, 32'h0);
        rdc(4'h0, 32'h1);
        $display("test registers done");
        for (int r = 0; r < 4; r++) begin
            for (int k = 1; k < 7; k++)
                op({r[0], 3'(k), 12'($urandom)}, 2'(r));
            op({7'h3C, 9'($urandom)}, 2'(r));
            for (int k = 9'h028; k < 9'h034; k++)
                op({1'($urandom), 9'(k), 6'($urandom)}, 2'(r));
            foreach (full[i])
                op({full[i], 6'($urandom)}, 2'(r));
        end
        idle(3);
        $display("test table sweep done");
        repeat (300) begin
            if ($urandom % 4 == 0) idle(1);
            op(16'($urandom), 2'($urandom));
        end
        idle(3);
        $display("test random stream done");
        bus(1'b1, 4'h8, 32'h0, 4'hF);
        bus(1'b1, 4'h0, 32'h0, 4'h1);
        repeat (5) op(16'h6000, 2'b11);
        idle(3);
        rdc(4'h8, 32'h5);
        rdc(4'hC, {16'h0, last_m});
        bus(1'b1, 4'h0, 32'h1, 4'h1);
        op(16'h0C00, 2'b01);
        op(16'h0CC0, 2'b10);
        idle(3);
        $display("test decode disable done");
        bus(1'b1, 4'h0, 32'h93, 4'h1);
        op(16'h6000, 2'b00);
        op(16'h0C00, 2'b01);
        idle(3);
        bus(1'b1, 4'h0, 32'h1, 4'h1);
        $display("test forced code done");
        report_and_stop();
    end
endmodule
